// ---- core/tag_cfg_map.svh ----
// Purpose: Offsets, field positions, reset values and code tables.
// Assumes: Included by the lock guard, register slave, top level and bench; not by the package or interface.
// Notes:   Definitions only.
`ifndef TAG_CFG_MAP_SVH
`define TAG_CFG_MAP_SVH

`define REG_EE_ADDR       8'h00
`define REG_EE_DATA       8'h04
`define REG_STATUS        8'h08
`define REG_CONFIG        8'h0C

`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`define RESP_DECERR       2'h3

`define WORD_UID          5'h00
`define WORD_FAB          5'h01
`define WORD_CFG          5'h02
`define WORD_WLOCK        5'h03
`define WORD_RLOCK        5'h04
`define WORD_COUNT        32
`define WLOCK_FREEZE_BIT  2
`define CFG_RESET         32'h2600_0000

`define CFG_NL4           16
`define CFG_NFC           15
`define CFG_PU_IRQ        14
`define CFG_ACT_IRQ       13
`define CFG_MODE_HI       12
`define CFG_MODE_LO       11
`define CFG_RXNCRC        10
`define CFG_RXBS          9
`define CFG_TXNCRC        8
`define CFG_TXBS          7
`define CFG_FDEL_HI       6
`define CFG_FDEL_LO       5
`define CFG_VREG_HI       4
`define CFG_VREG_LO       3
`define CFG_RREG_HI       2
`define CFG_RREG_LO       1

`define FDEL_PERIODS_00   4'h6
`define FDEL_PERIODS_01   4'h4
`define FDEL_PERIODS_10   4'h2
`define FDEL_PERIODS_11   4'h8

`define RAIL_MV_00        12'h708
`define RAIL_MV_01        12'h7D0
`define RAIL_MV_10        12'hA8C
`define RAIL_MV_11        12'hCE4

`define REG_OHMS_01       7'h64
`define REG_OHMS_10       7'h32
`define REG_OHMS_11       7'h19

`endif

// ---- core/tag_cfg_pkg.sv ----
// Purpose: Types shared by the configuration and lock block.
// Assumes: Nothing beyond the map header.
// Notes:   Codes are one-hot.
package tag_cfg_pkg;

  typedef enum logic [3:0] {
    MODE_L4          = 4'b0001,
    MODE_L3          = 4'b0010,
    MODE_FRAMING     = 4'b0100,
    MODE_TRANSPARENT = 4'b1000
  } op_mode_t;

  typedef enum logic [6:0] {
    AX_IDLE  = 7'b000_0001,
    AX_WACC  = 7'b000_0010,
    AX_WNVM  = 7'b000_0100,
    AX_BRESP = 7'b000_1000,
    AX_RACC  = 7'b001_0000,
    AX_RNVM  = 7'b010_0000,
    AX_RRESP = 7'b100_0000
  } axil_state_t;

endpackage

// ---- core/nvm_req_if.sv ----
// Purpose: Word access request from the register slave to the array.
// Assumes: Request held until the one-cycle grant.
// Notes:   Grant, data and refusal are valid together.
`timescale 1ns/1ps
`default_nettype none
interface nvm_req_if;
  logic        req;
  logic        we;
  logic [4:0]  addr;
  logic [31:0] wdata;
  logic        gnt;
  logic [31:0] rdata;
  logic        refused;
  modport initiator (output req, we, addr, wdata,
                     input gnt, rdata, refused);
  modport target    (input req, we, addr, wdata,
                     output gnt, rdata, refused);
endinterface
`default_nettype wire

// ---- core/nvm_lock_guard.sv ----
// Purpose: Decides whether a word access is allowed by the lock words.
// Assumes: Lock words come straight from the array.
// Notes:   Purely combinational.
`timescale 1ns/1ps
`default_nettype none
`include "tag_cfg_map.svh"
module nvm_lock_guard (
  input  wire logic [4:0]  addr_i,
  input  wire logic        rf_side_i,
  input  wire logic [31:0] wlock_i,
  input  wire logic [31:0] rlock_i,
  output logic             wr_ok_o,
  output logic             rd_ok_o
);
  logic lock_word;

  assign lock_word = (addr_i == `WORD_WLOCK) || (addr_i == `WORD_RLOCK);
  // Word 0 and word 1 are read only; the lock bit of word 0 is moot.
  assign wr_ok_o = (addr_i > `WORD_FAB) && !wlock_i[addr_i] // R15 R16
                   && !(wlock_i[`WLOCK_FREEZE_BIT] && lock_word); // R17
  // The first five words stay readable from the field whatever locks say.
  assign rd_ok_o = !rf_side_i || (addr_i <= `WORD_RLOCK) // R18 R19
                   || !rlock_i[addr_i];
endmodule
`default_nettype wire

// ---- core/axil_regs.sv ----
// Purpose: AXI4-Lite slave for the word window and status registers.
// Assumes: One write or one read at a time; full strobes on data.
// Notes:   Waits for both write address and data before taking either.
`timescale 1ns/1ps
`default_nettype none
`include "tag_cfg_map.svh"
module axil_regs (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic [7:0]  awaddr_i,
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  output logic [1:0]       bresp_o,
  output logic             bvalid_o,
  input  wire logic        bready_i,
  input  wire logic [7:0]  araddr_i,
  input  wire logic        arvalid_i,
  output logic             arready_o,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  input  wire logic [31:0] status_i,
  input  wire logic [31:0] config_i,
  nvm_req_if.initiator     nvm
);
  tag_cfg_pkg::axil_state_t state_q;
  logic [4:0]  ee_addr_q;
  logic        req_q;
  logic        we_q;
  logic [31:0] wdata_q;

  assign nvm.req   = req_q;
  assign nvm.we    = we_q;
  assign nvm.addr  = ee_addr_q;
  assign nvm.wdata = wdata_q;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_q   <= tag_cfg_pkg::AX_IDLE;
      awready_o <= 1'b0;
      wready_o  <= 1'b0;
      arready_o <= 1'b0;
      bvalid_o  <= 1'b0;
      bresp_o   <= `RESP_OKAY;
      rvalid_o  <= 1'b0;
      rresp_o   <= `RESP_OKAY;
      rdata_o   <= 32'h0000_0000;
      ee_addr_q <= 5'h00;
      req_q     <= 1'b0;
      we_q      <= 1'b0;
      wdata_q   <= 32'h0000_0000;
    end else begin
      case (state_q)
        tag_cfg_pkg::AX_IDLE: begin
          if (awvalid_i && wvalid_i) begin
            awready_o <= 1'b1;
            wready_o  <= 1'b1;
            state_q   <= tag_cfg_pkg::AX_WACC;
          end else if (arvalid_i) begin
            arready_o <= 1'b1;
            state_q   <= tag_cfg_pkg::AX_RACC;
          end
        end
        tag_cfg_pkg::AX_WACC: begin
          awready_o <= 1'b0;
          wready_o  <= 1'b0;
          bresp_o   <= `RESP_OKAY;
          state_q   <= tag_cfg_pkg::AX_BRESP;
          bvalid_o  <= 1'b1;
          if (awaddr_i == `REG_EE_ADDR) begin
            if (wstrb_i[0]) begin
              ee_addr_q <= wdata_i[4:0];
            end
          end else if (awaddr_i == `REG_EE_DATA) begin
            if (wstrb_i == 4'hF) begin
              req_q    <= 1'b1;
              we_q     <= 1'b1;
              wdata_q  <= wdata_i;
              bvalid_o <= 1'b0;
              state_q  <= tag_cfg_pkg::AX_WNVM;
            end else begin
              bresp_o <= `RESP_SLVERR;
            end
          end else if (awaddr_i != `REG_STATUS &&
                       awaddr_i != `REG_CONFIG) begin
            bresp_o <= `RESP_DECERR;
          end
        end
        tag_cfg_pkg::AX_WNVM: begin
          if (nvm.gnt) begin
            req_q    <= 1'b0;
            bvalid_o <= 1'b1;
            bresp_o  <= nvm.refused ? `RESP_SLVERR : `RESP_OKAY; // R15
            state_q  <= tag_cfg_pkg::AX_BRESP;
          end
        end
        tag_cfg_pkg::AX_BRESP: begin
          if (bready_i) begin
            bvalid_o <= 1'b0;
            state_q  <= tag_cfg_pkg::AX_IDLE;
          end
        end
        tag_cfg_pkg::AX_RACC: begin
          arready_o <= 1'b0;
          rresp_o   <= `RESP_OKAY;
          rvalid_o  <= 1'b1;
          state_q   <= tag_cfg_pkg::AX_RRESP;
          case (araddr_i)
            `REG_EE_ADDR: rdata_o <= {27'h000_0000, ee_addr_q};
            `REG_STATUS:  rdata_o <= status_i;
            `REG_CONFIG:  rdata_o <= config_i;
            `REG_EE_DATA: begin
              req_q    <= 1'b1;
              we_q     <= 1'b0;
              rvalid_o <= 1'b0;
              state_q  <= tag_cfg_pkg::AX_RNVM;
            end
            default: begin
              rdata_o <= 32'h0000_0000;
              rresp_o <= `RESP_DECERR;
            end
          endcase
        end
        tag_cfg_pkg::AX_RNVM: begin
          if (nvm.gnt) begin
            req_q    <= 1'b0;
            rdata_o  <= nvm.rdata;
            rvalid_o <= 1'b1;
            state_q  <= tag_cfg_pkg::AX_RRESP;
          end
        end
        tag_cfg_pkg::AX_RRESP: begin
          if (rready_i) begin
            rvalid_o <= 1'b0;
            state_q  <= tag_cfg_pkg::AX_IDLE;
          end
        end
        default: state_q <= tag_cfg_pkg::AX_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- core/tag_config_and_lock_control.sv ----
// Purpose: Holds the 32-word nonvolatile array, decodes the configuration
//          word and enforces the one-time-programmable lock words.
// Assumes: Field-side requests are one-cycle pulses synchronous to clk_i.
// Notes:   Field side has priority over the register window.
`timescale 1ns/1ps
`default_nettype none
`include "tag_cfg_map.svh"

// How it works
// R1 - Power-up done raises interrupt when enabled
// R2 - Active entry interrupts in Level-3/Level-4 modes
// R3 - Mode 00 Level-4, 11 transparent
// R4 - Mode 01 Level-3, 10 framing
// R5 - Receive CRC unchecked, kept in FIFO
// R6 - Receive bit-stream, no parity or CRC
// R7 - Transmit without appended CRC
// R8 - Transmit raw bits, no parity or CRC
// R9 - Options live in Level-3/framing, Level-4 FIFO frames
// R10 - Frame delay codes give 6,4,2,8 periods
// R11 - Rail voltage 1.8, 2.0, 2.7, 3.3 V
// R12 - Regulator off or 100/50/25 ohm
// R13 - Not-Level-4 flag beats NFC target flag
// R14 - Lock word bits never return to zero
// R15 - Write-locked word refuses writes, both sides
// R16 - Word 0 always read only
// R17 - Lock bit 2 freezes lock words
// R18 - Read-locked word refused to field side
// R19 - Words 0 to 4 always field-readable
// R20 - Thirty-two words; config, locks, user data
module tag_config_and_lock_control #(
  parameter logic [31:0] UID_WORD = 32'h0000_0001, // Arbitrary value.
  parameter logic [31:0] FAB_WORD = 32'h0000_0002  // Arbitrary value.
) (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic [7:0]  awaddr_i,
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  output logic [1:0]       bresp_o,
  output logic             bvalid_o,
  input  wire logic        bready_i,
  input  wire logic [7:0]  araddr_i,
  input  wire logic        arvalid_i,
  output logic             arready_o,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  input  wire logic        rf_req_i,
  input  wire logic        rf_we_i,
  input  wire logic [4:0]  rf_addr_i,
  input  wire logic [31:0] rf_wdata_i,
  output logic             rf_done_o,
  output logic             rf_refused_o,
  output logic [31:0]      rf_rdata_o,
  input  wire logic        powerup_done_i,
  input  wire logic        active_entry_i,
  input  wire logic        frame_via_fifo_i,
  output logic             irq_o,
  output logic [3:0]       op_mode_o,
  output logic             rx_skip_crc_o,
  output logic             rx_bitstream_o,
  output logic             tx_no_crc_o,
  output logic             tx_bitstream_o,
  output logic [3:0]       frame_delay_periods_o,
  output logic [11:0]      regulated_output_rail_mv_o,
  output logic             regulator_enable_o,
  output logic [6:0]       regulator_ohms_o,
  output logic             sak_not_level_four_flag_o,
  output logic             sak_nfc_target_o
);
  nvm_req_if nvm ();

  tag_cfg_pkg::op_mode_t mode_q;
  logic [31:0] mem_q [`WORD_COUNT];
  logic [31:0] cfg;
  logic [31:0] wlock;
  logic [31:0] rlock;
  logic        use_rf;
  logic        use_spi;
  logic [4:0]  acc_addr;
  logic        acc_we;
  logic [31:0] acc_data;
  logic        wr_ok;
  logic        rd_ok;
  logic        wr_en;
  logic        gnt_q;
  logic        refused_q;
  logic [31:0] nvm_rdata_q;
  logic        pu_done_q;
  logic        opt_live;

  assign cfg   = mem_q[`WORD_CFG];
  assign wlock = mem_q[`WORD_WLOCK];
  assign rlock = mem_q[`WORD_RLOCK];

  ////////////////////////////////////////////////////////////////////////////
  axil_regs u_regs (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .awaddr_i  (awaddr_i),
    .awvalid_i (awvalid_i),
    .awready_o (awready_o),
    .wdata_i   (wdata_i),
    .wstrb_i   (wstrb_i),
    .wvalid_i  (wvalid_i),
    .wready_o  (wready_o),
    .bresp_o   (bresp_o),
    .bvalid_o  (bvalid_o),
    .bready_i  (bready_i),
    .araddr_i  (araddr_i),
    .arvalid_i (arvalid_i),
    .arready_o (arready_o),
    .rdata_o   (rdata_o),
    .rresp_o   (rresp_o),
    .rvalid_o  (rvalid_o),
    .rready_i  (rready_i),
    .status_i  ({27'h000_0000, pu_done_q, op_mode_o}),
    .config_i  (cfg),
    .nvm       (nvm.initiator)
  );

  // The register side is the host's side, so its reads are never refused.
  nvm_lock_guard u_guard (
    .addr_i    (acc_addr),
    .rf_side_i (use_rf),
    .wlock_i   (wlock),
    .rlock_i   (rlock),
    .wr_ok_o   (wr_ok),
    .rd_ok_o   (rd_ok)
  );

  ////////////////////////////////////////////////////////////////////////////
  // A window request waits while the field side is busy; the grant pulse
  // itself blocks a second service of the same held request.
  assign use_rf   = rf_req_i;
  assign use_spi  = nvm.req && !gnt_q && !rf_req_i;
  assign acc_addr = use_rf ? rf_addr_i : nvm.addr;
  assign acc_we   = use_rf ? rf_we_i : nvm.we;
  assign acc_data = use_rf ? rf_wdata_i : nvm.wdata;
  assign wr_en    = (use_rf || use_spi) && acc_we && wr_ok; // R15

  assign nvm.gnt     = gnt_q;
  assign nvm.rdata   = nvm_rdata_q;
  assign nvm.refused = refused_q;

  generate
    for (genvar g = 0; g < `WORD_COUNT; g++) begin : g_word // R20
      localparam logic [31:0] RST = (g == 0) ? UID_WORD :
                                    (g == 1) ? FAB_WORD :
                                    (g == 2) ? `CFG_RESET : 32'h0000_0000;
      localparam logic OTP = (g == 3) || (g == 4);
      always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
          mem_q[g] <= RST;
        end else if (wr_en && acc_addr == 5'(g)) begin
          // Lock words only ever gain set bits.
          mem_q[g] <= OTP ? (mem_q[g] | acc_data) : acc_data; // R14
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rf_done_o    <= 1'b0;
      rf_refused_o <= 1'b0;
      rf_rdata_o   <= 32'h0000_0000;
    end else begin
      rf_done_o    <= use_rf;
      rf_refused_o <= use_rf && (rf_we_i ? !wr_ok : !rd_ok); // R15 R18
      if (use_rf) begin
        rf_rdata_o <= (!rf_we_i && rd_ok) ? mem_q[rf_addr_i] // R19
                                          : 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      gnt_q       <= 1'b0;
      refused_q   <= 1'b0;
      nvm_rdata_q <= 32'h0000_0000;
    end else begin
      gnt_q     <= use_spi;
      refused_q <= use_spi && nvm.we && !wr_ok; // R15
      if (use_spi) begin
        nvm_rdata_q <= mem_q[nvm.addr];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      mode_q <= tag_cfg_pkg::MODE_L4;
    end else begin
      case (cfg[`CFG_MODE_HI:`CFG_MODE_LO])
        2'b00:   mode_q <= tag_cfg_pkg::MODE_L4; // R3
        2'b01:   mode_q <= tag_cfg_pkg::MODE_L3; // R4
        2'b10:   mode_q <= tag_cfg_pkg::MODE_FRAMING; // R4
        2'b11:   mode_q <= tag_cfg_pkg::MODE_TRANSPARENT; // R3
        default: mode_q <= tag_cfg_pkg::MODE_L4;
      endcase
    end
  end

  assign opt_live = (mode_q == tag_cfg_pkg::MODE_L3) || // R9
                    (mode_q == tag_cfg_pkg::MODE_FRAMING) ||
                    (mode_q == tag_cfg_pkg::MODE_L4 && frame_via_fifo_i);

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      op_mode_o      <= 4'b0001;
      rx_skip_crc_o  <= 1'b0;
      rx_bitstream_o <= 1'b0;
      tx_no_crc_o    <= 1'b0;
      tx_bitstream_o <= 1'b0;
    end else begin
      op_mode_o      <= mode_q;
      rx_skip_crc_o  <= opt_live && cfg[`CFG_RXNCRC]; // R5
      rx_bitstream_o <= opt_live && cfg[`CFG_RXBS]; // R6
      tx_no_crc_o    <= opt_live && cfg[`CFG_TXNCRC]; // R7
      tx_bitstream_o <= opt_live && cfg[`CFG_TXBS]; // R8
    end
  end

  // Analog settings follow the stored word one cycle later.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      frame_delay_periods_o      <= `FDEL_PERIODS_00;
      regulated_output_rail_mv_o <= `RAIL_MV_00;
      regulator_enable_o         <= 1'b0;
      regulator_ohms_o           <= 7'h00;
    end else begin
      case (cfg[`CFG_FDEL_HI:`CFG_FDEL_LO])
        2'b00:   frame_delay_periods_o <= `FDEL_PERIODS_00; // R10
        2'b01:   frame_delay_periods_o <= `FDEL_PERIODS_01; // R10
        2'b10:   frame_delay_periods_o <= `FDEL_PERIODS_10; // R10
        default: frame_delay_periods_o <= `FDEL_PERIODS_11; // R10
      endcase
      case (cfg[`CFG_VREG_HI:`CFG_VREG_LO])
        2'b00:   regulated_output_rail_mv_o <= `RAIL_MV_00; // R11
        2'b01:   regulated_output_rail_mv_o <= `RAIL_MV_01; // R11
        2'b10:   regulated_output_rail_mv_o <= `RAIL_MV_10; // R11
        default: regulated_output_rail_mv_o <= `RAIL_MV_11; // R11
      endcase
      regulator_enable_o <= |cfg[`CFG_RREG_HI:`CFG_RREG_LO]; // R12
      case (cfg[`CFG_RREG_HI:`CFG_RREG_LO])
        2'b01:   regulator_ohms_o <= `REG_OHMS_01; // R12
        2'b10:   regulator_ohms_o <= `REG_OHMS_10; // R12
        2'b11:   regulator_ohms_o <= `REG_OHMS_11; // R12
        default: regulator_ohms_o <= 7'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sak_not_level_four_flag_o <= 1'b0;
      sak_nfc_target_o          <= 1'b0;
    end else begin
      sak_not_level_four_flag_o <= cfg[`CFG_NL4];
      sak_nfc_target_o <= cfg[`CFG_NFC] && !cfg[`CFG_NL4]; // R13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The power-up request is a one-cycle pulse; the active-entry request follows active_entry_i while it is high; the register side does not latch them.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pu_done_q <= 1'b0;
      irq_o     <= 1'b0;
    end else begin
      pu_done_q <= powerup_done_i;
      irq_o <= (powerup_done_i && !pu_done_q && cfg[`CFG_PU_IRQ]) || // R1
               (active_entry_i && cfg[`CFG_ACT_IRQ] && // R2
                (mode_q == tag_cfg_pkg::MODE_L3 ||
                 mode_q == tag_cfg_pkg::MODE_L4));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_lock_sticky;
    @(posedge clk_i) disable iff (!resetn_i)
      ##1 ((mem_q[3] & $past(mem_q[3])) == $past(mem_q[3])) &&
          ((mem_q[4] & $past(mem_q[4])) == $past(mem_q[4]));
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) // R14
    else $error("A lock bit returned to zero.");

  property p_rf_wlock;
    @(posedge clk_i) disable iff (!resetn_i)
      rf_req_i && rf_we_i && wlock[rf_addr_i]
      |=> rf_done_o && rf_refused_o && $stable(mem_q[$past(rf_addr_i)]);
  endproperty
  a_rf_wlock: assert property (p_rf_wlock) // R15
    else $error("Field write to a locked word was not refused.");

  property p_word0_ro;
    @(posedge clk_i) disable iff (!resetn_i)
      wr_en |-> acc_addr != `WORD_UID;
  endproperty
  a_word0_ro: assert property (p_word0_ro) // R16
    else $error("Word 0 was written.");

  property p_freeze;
    @(posedge clk_i) disable iff (!resetn_i)
      wlock[`WLOCK_FREEZE_BIT] |=> $stable(mem_q[3]) && $stable(mem_q[4]);
  endproperty
  a_freeze: assert property (p_freeze) // R17
    else $error("Lock words changed after the freeze bit was set.");

  property p_rf_rlock;
    @(posedge clk_i) disable iff (!resetn_i)
      rf_req_i && !rf_we_i && rf_addr_i > `WORD_RLOCK && rlock[rf_addr_i]
      |=> rf_refused_o && rf_rdata_o == 32'h0000_0000;
  endproperty
  a_rf_rlock: assert property (p_rf_rlock) // R18
    else $error("Field read of a read-locked word was not refused.");

  property p_low_words_readable;
    @(posedge clk_i) disable iff (!resetn_i)
      rf_req_i && !rf_we_i && rf_addr_i <= `WORD_RLOCK
      |=> !rf_refused_o && rf_rdata_o == mem_q[$past(rf_addr_i)];
  endproperty
  a_low_words_readable: assert property (p_low_words_readable) // R19
    else $error("Field read of words 0 to 4 was refused.");

  property p_mode_l4;
    @(posedge clk_i) disable iff (!resetn_i)
      cfg[`CFG_MODE_HI:`CFG_MODE_LO] == 2'b00 [*2]
      |-> ##1 op_mode_o == 4'b0001;
  endproperty
  a_mode_l4: assert property (p_mode_l4) // R3
    else $error("Mode code 00 did not select Level-4.");

  property p_fdel_max;
    @(posedge clk_i) disable iff (!resetn_i)
      cfg[`CFG_FDEL_HI:`CFG_FDEL_LO] == 2'b11 |=> frame_delay_periods_o == 4'h8;
  endproperty
  a_fdel_max: assert property (p_fdel_max) // R10
    else $error("Frame delay code 11 did not give 8 periods.");

  property p_pu_irq;
    @(posedge clk_i) disable iff (!resetn_i)
      $rose(powerup_done_i) && cfg[`CFG_PU_IRQ] |=> irq_o;
  endproperty
  a_pu_irq: assert property (p_pu_irq) // R1
    else $error("Power-up interrupt missing.");

  property p_nl4_wins;
    @(posedge clk_i) disable iff (!resetn_i)
      cfg[`CFG_NL4] |=> !sak_nfc_target_o;
  endproperty
  a_nl4_wins: assert property (p_nl4_wins) // R13
    else $error("NFC target flag reported despite not-Level-4.");

endmodule
`default_nettype wire

// ---- test/rf_reader_model.sv ----
// Purpose: Field-side reader model issuing single word accesses.
// Assumes: The block answers one cycle after the request edge.
// Notes:   Released lines show the inverse so stale values never pass.
`timescale 1ns/1ps
`default_nettype none
module rf_reader_model (
  input  wire logic        clk_i,
  output logic             req_o,
  output logic             we_o,
  output logic [4:0]       addr_o,
  output logic [31:0]      wdata_o,
  input  wire logic        done_i,
  input  wire logic        refused_i,
  input  wire logic [31:0] rdata_i
);
  initial {req_o, we_o, addr_o, wdata_o} = '0;
  task automatic access(input logic w, input logic [4:0] a,
                        input logic [31:0] d, output logic [33:0] q);
    @(posedge clk_i);
    {req_o, we_o, addr_o, wdata_o} <= {1'b1, w, a, d};
    @(posedge clk_i);
    {req_o, we_o, addr_o, wdata_o} <= {1'b0, ~w, ~a, ~d};
    @(posedge clk_i);
    q = {done_i, refused_i, rdata_i};
  endtask
endmodule
`default_nettype wire

// ---- test/tag_config_and_lock_control_tb_top.sv ----
// Purpose: Self-checking bench for the configuration and lock block.
// Assumes: Bus answers come well before the watchdog runs out.
// Notes:   Field accesses go through the reader model.
`timescale 1ns/1ps
`default_nettype none
`include "tag_cfg_map.svh"
module tag_config_and_lock_control_tb_top;
  logic clk_i = 0, resetn_i = 0, pu = 0, act = 0, fifo = 0;
  logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, awr, bv, arr, rv;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd, rwd, rrd;
  logic [1:0] br, rr;
  logic rq, we, dn, rf, irq, rbs, reg_en, nlf, nfc, wr, rsc, tnc, tbs;
  logic [4:0] ad;
  logic [3:0] mode, fdel;
  logic [11:0] mv;
  logic [6:0] ohm;
  logic [33:0] r;
  int mismatches = 0, tests_run = 0;
  localparam logic [31:0] fd_tab[4] = '{32'h6, 32'h4, 32'h2, 32'h8};
  localparam logic [31:0] mv_tab[4] = '{32'h708, 32'h7D0, 32'hA8C, 32'hCE4};
  localparam logic [31:0] om_tab[4] = '{32'h0, 32'h64, 32'h32, 32'h19};
  always #20 clk_i = ~clk_i;
  tag_config_and_lock_control u_tag_config_and_lock_control (
    .clk_i, .resetn_i, .awaddr_i(awa), .awvalid_i(awv), .awready_o(awr),
    .wdata_i(wd), .wstrb_i(4'hF), .wvalid_i(wv), .wready_o(wr),
    .bresp_o(br), .bvalid_o(bv), .bready_i(bry), .araddr_i(ara),
    .arvalid_i(arv), .arready_o(arr), .rdata_o(rd), .rresp_o(rr),
    .rvalid_o(rv), .rready_i(rry), .rf_req_i(rq), .rf_we_i(we),
    .rf_addr_i(ad), .rf_wdata_i(rwd), .rf_done_o(dn), .rf_refused_o(rf),
    .rf_rdata_o(rrd), .powerup_done_i(pu), .active_entry_i(act),
    .frame_via_fifo_i(fifo), .irq_o(irq), .op_mode_o(mode),
    .rx_skip_crc_o(rsc), .rx_bitstream_o(rbs), .tx_no_crc_o(tnc),
    .tx_bitstream_o(tbs), .frame_delay_periods_o(fdel),
    .regulated_output_rail_mv_o(mv), .regulator_enable_o(reg_en),
    .regulator_ohms_o(ohm), .sak_not_level_four_flag_o(nlf),
    .sak_nfc_target_o(nfc));
  rf_reader_model u_rf_reader_model (.clk_i, .req_o(rq), .we_o(we),
    .addr_o(ad), .wdata_o(rwd), .done_i(dn), .refused_i(rf), .rdata_i(rrd));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Both write channels are offered together and dropped once taken.
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] e);
    @(posedge clk_i);
    {awa, wd, awv, wv, bry} <= {a, d, 3'b111};
    do begin
      @(posedge clk_i);
      if (awr === 1'b1) awv <= 1'b0;
      if (wr === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1);
    bry <= 1'b0;
    chk(32'(br), 32'(e));
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] e);
    @(posedge clk_i);
    {ara, arv, rry} <= {a, 2'b11};
    do begin
      @(posedge clk_i);
      if (arr === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1);
    rry <= 1'b0;
    chk(32'(rr), 32'(e));
    if (e == `RESP_OKAY) chk(rd, d);
  endtask
  task automatic eew(input logic [4:0] n, input logic [31:0] d,
                     input logic [1:0] e);
    axw(`REG_EE_ADDR, 32'(n), `RESP_OKAY);
    axw(`REG_EE_DATA, d, e);
  endtask
  task automatic eer(input logic [4:0] n, input logic [31:0] d);
    axw(`REG_EE_ADDR, 32'(n), `RESP_OKAY);
    axr(`REG_EE_DATA, d, `RESP_OKAY);
  endtask
  task automatic fa(input logic w, input logic [4:0] n, input logic [31:0] d);
    u_rf_reader_model.access(w, n, d, r);
    chk(32'(r[33]), 32'h1);
  endtask
  task automatic t_decode;
    axr(`REG_CONFIG, `CFG_RESET, `RESP_OKAY);
    axr(8'h10, 32'h0, `RESP_DECERR);
    for (int c = 0; c < 4; c++) begin
      fa(1'b1, `WORD_CFG, 32'h4780 | c << 11 | c << 5 | c << 3 | c << 1);
      repeat (4) @(posedge clk_i);
      chk(32'(mode), 32'h1 << c);
      chk(32'({rsc, rbs, tnc, tbs}), (c % 3 != 0) * 15);
      chk(32'(fdel), fd_tab[c]);
      chk(32'(mv), mv_tab[c]);
      chk(32'(ohm), om_tab[c]);
      chk(32'(reg_en), 32'(c != 0));
    end
    pu <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(32'(irq), 32'h1);
    @(posedge clk_i);
    chk(32'(irq), 32'h0);
    fifo <= 1'b1;
    fa(1'b1, `WORD_CFG, 32'h0001_A200);
    repeat (4) @(posedge clk_i);
    chk(32'(rbs), 32'h1);
    chk(32'({nlf, nfc}), 32'h2);
    act <= 1'b1;
    @(posedge clk_i);
    act <= 1'b0;
    @(posedge clk_i);
    chk(32'(irq), 32'h1);
  endtask
  task automatic t_locks;
    fa(1'b1, 5'd6, 32'h0000_A5A5);
    eew(`WORD_WLOCK, 32'h20, `RESP_OKAY);
    fa(1'b1, 5'd5, 32'h1);
    chk(32'(r[33:32]), 32'h3);
    eew(5'd5, 32'h1, `RESP_SLVERR);
    fa(1'b1, `WORD_UID, 32'h1);
    chk(32'(r[33:32]), 32'h3);
    eew(`WORD_RLOCK, 32'h50, `RESP_OKAY);
    fa(1'b0, 5'd6, 32'h0);
    chk(r[31:0], 32'h0);
    chk(32'(r[32]), 32'h1);
    fa(1'b0, `WORD_RLOCK, 32'h0);
    chk(r[31:0], 32'h50);
    eer(5'd6, 32'h0000_A5A5);
    eew(`WORD_WLOCK, 32'h0, `RESP_OKAY);
    eer(`WORD_WLOCK, 32'h20);
    eew(`WORD_WLOCK, 32'h4, `RESP_OKAY);
    eew(`WORD_RLOCK, 32'h100, `RESP_SLVERR);
    eer(`WORD_RLOCK, 32'h50);
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_decode();
    t_locks();
    finish_test();
  end
  initial begin
    #(40 * 20000);
    mismatches++;
    finish_test();
  end
endmodule
`default_nettype wire
